/* File: rtl/dtli_pkg.sv */
// Constants for the transfer and load-immediate executor
package dtli_pkg;

	// Widths
	localparam int DATA_W = 32;
	localparam int PTR_W = 6;
	localparam int PC_W = 8;
	localparam int BANKS = 4;
	localparam int BANK_DEPTH = 64;

	// Instruction groups in bits 31..30
	localparam logic [1:0] GRP_OPERATION = 2'h0;
	localparam logic [1:0] GRP_LOAD_IMM = 2'h2;
	// Move field kind in bits 13..12 of an operation word
	localparam logic [1:0] MOVE_SHORT_IMM = 2'h1;
	localparam logic [1:0] MOVE_REG_RAM = 2'h3;

	// Field positions
	localparam int GRP_MSB = 31;
	localparam int GRP_LSB = 30;
	localparam int MOVE_KIND_MSB = 13;
	localparam int MOVE_KIND_LSB = 12;
	localparam int MOVE_DEST_MSB = 11;
	localparam int MOVE_DEST_LSB = 8;
	localparam int SIMM_MSB = 7;
	localparam int SRC_MSB = 3;
	localparam int LI_DEST_MSB = 29;
	localparam int LI_DEST_LSB = 26;
	localparam int LI_COND_BIT = 25;
	localparam int UIMM_MSB = 24;
	localparam int COND_MSB = 24;
	localparam int COND_LSB = 19;
	localparam int CIMM_MSB = 18;
	localparam int COND_POL_BIT = 5;

	// Condition flag select bits in the condition field
	localparam logic [3:0] CSEL_ZERO = 4'h1;
	localparam logic [3:0] CSEL_SIGN = 4'h2;
	localparam logic [3:0] CSEL_CARRY = 4'h4;
	localparam logic [3:0] CSEL_BUSY = 4'h8;

	// Destination codes
	localparam logic [3:0] DST_BANK3 = 4'h3;
	localparam logic [3:0] DST_MUL_X = 4'h4;
	localparam logic [3:0] DST_PRODUCT_LOW = 4'h5;
	localparam logic [3:0] DST_READ_ADDR = 4'h6;
	localparam logic [3:0] DST_WRITE_ADDR = 4'h7;
	localparam logic [3:0] DST_LOOP = 4'hA;
	localparam logic [3:0] DST_RETURN = 4'hB;
	localparam logic [3:0] DST_PROG_COUNTER = 4'hC;
	localparam logic [3:0] DST_PTR0 = 4'hC;

	// Source codes
	localparam logic [3:0] SRC_BANK_PLAIN3 = 4'h3;
	localparam logic [3:0] SRC_BANK_INC3 = 4'h7;
	localparam logic [3:0] SRC_ALU_LOW = 4'h9;
	localparam logic [3:0] SRC_ALU_HIGH = 4'hA;

	// Register map, byte addresses
	localparam logic [5:0] REG_CONTROL = 6'h00;
	localparam logic [5:0] REG_STATUS = 6'h04;
	localparam logic [5:0] REG_PROG_COUNTER = 6'h08;
	localparam logic [5:0] REG_RETURN = 6'h0C;
	localparam logic [5:0] REG_LOOP = 6'h10;
	localparam logic [5:0] REG_MUL_X = 6'h14;
	localparam logic [5:0] REG_PRODUCT_LOW = 6'h18;
	localparam logic [5:0] REG_READ_ADDR = 6'h1C;
	localparam logic [5:0] REG_WRITE_ADDR = 6'h20;
	localparam logic [5:0] REG_POINTERS = 6'h24;

	// Reset values and step sizes
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam logic [PTR_W-1:0] RESET_PTR = 6'h00;
	localparam logic [PC_W-1:0] RESET_PC = 8'h00;
	localparam logic [PC_W-1:0] PC_STEP = 8'h01;
	localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;

endpackage : dtli_pkg

/* File: rtl/dtli_exec.sv */
// Decode and execution of data-transfer and load-immediate instructions
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// How it works
// - Short immediate sign-extends bit 7 upward
// - Codes 0-3 banks with pointer advance, 4-7 registers
// - Move destinations include loop, return, pointers
// - Register/RAM move copies source unchanged
// - Sources: banks plain or advancing, ALU halves
// - Advancing selector addresses by pointer, then increments
// - Moves touch only destination and advancing source pointer, never flags
// - Unconditional load writes 25-bit signed immediate
// - Load destinations limited, program counter included
// - Conditional loads sign-extend 19 bits, write if true
// - Zero variant writes when zero flag set
// - Not-zero variant writes when zero flag clear
// - Sign variant writes when sign flag set
// - Not-sign variant writes when sign flag clear
// - Carry variant writes when carry flag set
// - Conditional load to counter saves return address
// - Sign flag comes from last ALU result
// - Busy set on transfer start, cleared at end
////////////////////////////////////////////////////////////////////////////
module dtli_exec (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Instruction stream from the sequencer
	input wire logic instr_valid_in,
	input wire logic [31:0] instr_in,
	output logic instr_ready_out,
	output logic [dtli_pkg::PC_W-1:0] prog_counter_out,
	// ALU flags and result
	input wire logic zero_flag_in,
	input wire logic sign_flag_in,
	input wire logic carry_flag_in,
	input wire logic [15:0] alu_high_part_in,
	input wire logic [31:0] alu_low_part_in,
	// External transfer events
	input wire logic transfer_start_in,
	input wire logic transfer_end_in,
	output logic transfer_busy_flag_out,
	// Avalon-MM slave
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] dtli_sext(input logic [31:0] raw,
		input int msb);
		logic [31:0] res;
		res = raw;
		for (int i = 0; i < 32; i++) begin
			if (i > msb) begin
				res[i] = raw[msb];
			end
		end
		return res;
	endfunction : dtli_sext

	// Bank code 0-3 in the low two bits when the upper two are zero
	function automatic logic dtli_is_bank(input logic [3:0] code);
		return code <= dtli_pkg::DST_BANK3;
	endfunction : dtli_is_bank

	////////////////////////////////////////////////////////////////////////
	// State
	logic [31:0] data_ram [dtli_pkg::BANKS][dtli_pkg::BANK_DEPTH];
	logic [dtli_pkg::PTR_W-1:0] ram_pointer [dtli_pkg::BANKS];
	logic [dtli_pkg::PTR_W-1:0] next_ram_pointer [dtli_pkg::BANKS];
	logic [31:0] mul_x_input, next_mul_x_input;
	logic [31:0] product_low_reg, next_product_low_reg;
	logic [31:0] external_read_address, next_external_read_address;
	logic [31:0] external_write_address, next_external_write_address;
	logic [31:0] loop_counter, next_loop_counter;
	logic [dtli_pkg::PC_W-1:0] return_address, next_return_address;
	logic [dtli_pkg::PC_W-1:0] prog_counter, next_prog_counter;
	logic jump_pending, next_jump_pending;
	logic [dtli_pkg::PC_W-1:0] jump_target, next_jump_target;
	logic transfer_busy_flag, next_transfer_busy_flag;
	logic run_enable, next_run_enable;
	logic waitreq, next_waitreq;
	logic [31:0] readdata, next_readdata;
	logic ram_we;
	logic [1:0] ram_we_bank;
	logic [31:0] ram_wdata;

	////////////////////////////////////////////////////////////////////////
	// Decode
	logic take;
	logic [1:0] grp;
	logic [1:0] move_kind;
	logic [3:0] dest;
	logic [3:0] src;
	logic [5:0] cond;
	logic cond_true;
	logic is_cond_load;
	logic do_write;
	logic [31:0] value;
	logic [31:0] src_word;
	logic [1:0] src_bank;

	assign take = instr_valid_in && run_enable;
	assign grp = instr_in[dtli_pkg::GRP_MSB:dtli_pkg::GRP_LSB];
	assign move_kind =
		instr_in[dtli_pkg::MOVE_KIND_MSB:dtli_pkg::MOVE_KIND_LSB];
	assign src = instr_in[dtli_pkg::SRC_MSB:0];
	assign src_bank = src[1:0];
	assign cond = instr_in[dtli_pkg::COND_MSB:dtli_pkg::COND_LSB];
	assign is_cond_load = instr_in[dtli_pkg::LI_COND_BIT];

	// Flags are sampled as the ALU left them; nothing here writes them
	always_comb begin
		logic [3:0] flags;
		flags = '0;
		flags[0] = zero_flag_in;
		flags[1] = sign_flag_in;
		flags[2] = carry_flag_in;
		flags[3] = transfer_busy_flag;
		// Polarity bit set means flag must be 1, clear means all 0
		cond_true = ((|(cond[3:0] & flags)) ==
			cond[dtli_pkg::COND_POL_BIT]);
		// Same test covers carry, not-carry and busy selects
		if (cond[3:0] == dtli_pkg::CSEL_CARRY ||
			cond[3:0] == dtli_pkg::CSEL_BUSY) begin
			cond_true = ((|(cond[3:0] & flags)) ==
				cond[dtli_pkg::COND_POL_BIT]);
		end
	end

	// Source read for register/RAM moves
	always_comb begin
		src_word = dtli_pkg::RESET_WORD;
		if (src <= dtli_pkg::SRC_BANK_INC3) begin
			src_word = data_ram[src_bank][ram_pointer[src_bank]];
		end else if (src == dtli_pkg::SRC_ALU_LOW) begin
			src_word = alu_low_part_in;
		end else if (src == dtli_pkg::SRC_ALU_HIGH) begin
			src_word = dtli_sext({16'h0000, alu_high_part_in}, 15);
		end
	end

	// Pick destination, value and whether the write happens
	always_comb begin
		dest = instr_in[dtli_pkg::MOVE_DEST_MSB:dtli_pkg::MOVE_DEST_LSB];
		value = src_word;
		do_write = 1'b0;
		if (take && grp == dtli_pkg::GRP_OPERATION) begin
			if (move_kind == dtli_pkg::MOVE_SHORT_IMM) begin
				value = dtli_sext({24'h00_0000, instr_in[7:0]},
					dtli_pkg::SIMM_MSB);
				do_write = 1'b1;
			end else if (move_kind == dtli_pkg::MOVE_REG_RAM) begin
				do_write = 1'b1;
			end
		end else if (take && grp == dtli_pkg::GRP_LOAD_IMM) begin
			dest = instr_in[dtli_pkg::LI_DEST_MSB:dtli_pkg::LI_DEST_LSB];
			if (is_cond_load) begin
				value = dtli_sext({13'h0000, instr_in[18:0]},
					dtli_pkg::CIMM_MSB);
				do_write = cond_true;
			end else begin
				value = dtli_sext({7'h00, instr_in[24:0]},
					dtli_pkg::UIMM_MSB);
				do_write = 1'b1;
			end
			// Loads reach neither return store nor pointers
			if (dest == dtli_pkg::DST_RETURN ||
				(dest > dtli_pkg::DST_PROG_COUNTER)) begin
				do_write = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Execute
	always_comb begin
		logic pc_dest;
		pc_dest = (grp == dtli_pkg::GRP_LOAD_IMM) &&
			(dest == dtli_pkg::DST_PROG_COUNTER);
		for (int b = 0; b < dtli_pkg::BANKS; b++) begin
			next_ram_pointer[b] = ram_pointer[b];
		end
		next_mul_x_input = mul_x_input;
		next_product_low_reg = product_low_reg;
		next_external_read_address = external_read_address;
		next_external_write_address = external_write_address;
		next_loop_counter = loop_counter;
		next_return_address = return_address;
		next_prog_counter = prog_counter;
		next_jump_pending = jump_pending;
		next_jump_target = jump_target;
		ram_we = 1'b0;
		ram_we_bank = dest[1:0];
		ram_wdata = value;
		if (take) begin
			// Jump lands after the delay-slot instruction
			if (jump_pending) begin
				next_prog_counter = jump_target;
				next_jump_pending = 1'b0;
			end else begin
				next_prog_counter = prog_counter + dtli_pkg::PC_STEP;
			end
			// Incrementing source advances its pointer after the read
			if (grp == dtli_pkg::GRP_OPERATION &&
				move_kind == dtli_pkg::MOVE_REG_RAM &&
				src > dtli_pkg::SRC_BANK_PLAIN3 &&
				src <= dtli_pkg::SRC_BANK_INC3) begin
				next_ram_pointer[src_bank] =
					ram_pointer[src_bank] + dtli_pkg::PTR_STEP;
			end
		end
		// Only the chosen destination (and its pointer, or the return store on a conditional call) changes; flags untouched
		if (do_write) begin
			if (dtli_is_bank(dest)) begin
				ram_we = 1'b1;
				next_ram_pointer[dest[1:0]] =
					next_ram_pointer[dest[1:0]] + dtli_pkg::PTR_STEP;
			end else if (pc_dest) begin
				next_jump_pending = 1'b1;
				next_jump_target = value[dtli_pkg::PC_W-1:0];
				if (is_cond_load) begin
					// Return lands on the delay-slot instruction again
					next_return_address =
						prog_counter + dtli_pkg::PC_STEP;
				end
			end else begin
				unique case (dest)
					dtli_pkg::DST_MUL_X:
						next_mul_x_input = value;
					dtli_pkg::DST_PRODUCT_LOW:
						next_product_low_reg = value;
					dtli_pkg::DST_READ_ADDR:
						next_external_read_address = value;
					dtli_pkg::DST_WRITE_ADDR:
						next_external_write_address = value;
					dtli_pkg::DST_LOOP:
						next_loop_counter = value;
					dtli_pkg::DST_RETURN:
						next_return_address =
							value[dtli_pkg::PC_W-1:0];
					default: begin
						if (dest >= dtli_pkg::DST_PTR0) begin
							next_ram_pointer[dest[1:0]] =
								value[dtli_pkg::PTR_W-1:0];
						end
						// Codes 8 and 9 fall through untouched
					end
				endcase
			end
		end
	end

	// Start wins over a simultaneous end, so no transfer goes unseen
	always_comb begin
		next_transfer_busy_flag = transfer_busy_flag;
		if (transfer_end_in) begin
			next_transfer_busy_flag = 1'b0;
		end
		if (transfer_start_in) begin
			next_transfer_busy_flag = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then the access completes
	always_comb begin
		logic hit;
		hit = (avs_read_in || avs_write_in) && waitreq;
		next_waitreq = !hit;
		next_readdata = readdata;
		next_run_enable = run_enable;
		if (hit && avs_read_in) begin
			unique case (avs_address_in)
				dtli_pkg::REG_CONTROL:
					next_readdata = {31'h0000_0000, run_enable};
				dtli_pkg::REG_STATUS:
					next_readdata = {30'h0000_0000, jump_pending,
						transfer_busy_flag};
				dtli_pkg::REG_PROG_COUNTER:
					next_readdata = {24'h00_0000, prog_counter};
				dtli_pkg::REG_RETURN:
					next_readdata = {24'h00_0000, return_address};
				dtli_pkg::REG_LOOP:
					next_readdata = loop_counter;
				dtli_pkg::REG_MUL_X:
					next_readdata = mul_x_input;
				dtli_pkg::REG_PRODUCT_LOW:
					next_readdata = product_low_reg;
				dtli_pkg::REG_READ_ADDR:
					next_readdata = external_read_address;
				dtli_pkg::REG_WRITE_ADDR:
					next_readdata = external_write_address;
				dtli_pkg::REG_POINTERS:
					next_readdata = {8'h00, ram_pointer[3], ram_pointer[2],
						ram_pointer[1], ram_pointer[0]};
				default:
					next_readdata = dtli_pkg::RESET_WORD;
			endcase
		end
		if (avs_write_in && !waitreq &&
			avs_address_in == dtli_pkg::REG_CONTROL) begin
			next_run_enable = avs_writedata_in[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			for (int b = 0; b < dtli_pkg::BANKS; b++) begin
				ram_pointer[b] <= dtli_pkg::RESET_PTR;
			end
			mul_x_input <= dtli_pkg::RESET_WORD;
			product_low_reg <= dtli_pkg::RESET_WORD;
			external_read_address <= dtli_pkg::RESET_WORD;
			external_write_address <= dtli_pkg::RESET_WORD;
			loop_counter <= dtli_pkg::RESET_WORD;
			return_address <= dtli_pkg::RESET_PC;
			prog_counter <= dtli_pkg::RESET_PC;
			jump_pending <= 1'b0;
			jump_target <= dtli_pkg::RESET_PC;
			transfer_busy_flag <= 1'b0;
			run_enable <= 1'b0;
			waitreq <= 1'b1;
			readdata <= dtli_pkg::RESET_WORD;
		end else begin
			for (int b = 0; b < dtli_pkg::BANKS; b++) begin
				ram_pointer[b] <= next_ram_pointer[b];
			end
			mul_x_input <= next_mul_x_input;
			product_low_reg <= next_product_low_reg;
			external_read_address <= next_external_read_address;
			external_write_address <= next_external_write_address;
			loop_counter <= next_loop_counter;
			return_address <= next_return_address;
			prog_counter <= next_prog_counter;
			jump_pending <= next_jump_pending;
			jump_target <= next_jump_target;
			transfer_busy_flag <= next_transfer_busy_flag;
			run_enable <= next_run_enable;
			waitreq <= next_waitreq;
			readdata <= next_readdata;
		end
	end

	// Data RAM has no reset; contents are undefined until written
	always_ff @(posedge clk_sys_in) begin
		if (ram_we) begin
			data_ram[ram_we_bank][ram_pointer[ram_we_bank]] <= ram_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign instr_ready_out = run_enable;
	assign prog_counter_out = prog_counter;
	assign transfer_busy_flag_out = transfer_busy_flag;
	assign avs_readdata_out = readdata;
	assign avs_waitrequest_out = waitreq;

endmodule : dtli_exec

/* File: tb/dtli_exec_properties.sv */
// Concurrent checks on the ports of the transfer and load executor
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module dtli_exec_properties (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Instruction stream
	input wire logic instr_valid_in,
	input wire logic [31:0] instr_in,
	input wire logic instr_ready_out,
	input wire logic [dtli_pkg::PC_W-1:0] prog_counter_out,
	// ALU and transfer events
	input wire logic zero_flag_in,
	input wire logic sign_flag_in,
	input wire logic carry_flag_in,
	input wire logic [15:0] alu_high_part_in,
	input wire logic [31:0] alu_low_part_in,
	input wire logic transfer_start_in,
	input wire logic transfer_end_in,
	input wire logic transfer_busy_flag_out,
	// Register bus
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////
	// Bus answers after exactly one wait cycle, for one cycle only
	wait_answer_a: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus request not answered in one cycle");
	wait_single_a: assert property (!avs_waitrequest_out |=>
		avs_waitrequest_out) else $error("waitrequest low too long");
	wait_cause_a: assert property (!avs_waitrequest_out |->
		$past(avs_read_in || avs_write_in)) else $error("answer unasked");
	read_hold_a: assert property (!avs_read_in |=>
		$stable(avs_readdata_out)) else $error("readdata moved unread");
	run_hold_a: assert property (!avs_write_in |=>
		$stable(instr_ready_out)) else $error("ready moved unwritten");
	// The counter only moves when a word is taken
	pc_hold_a: assert property (!(instr_valid_in && instr_ready_out) |=>
		$stable(prog_counter_out)) else $error("pc moved while idle");
	busy_set_a: assert property (transfer_start_in |=>
		transfer_busy_flag_out) else $error("busy not set on start");
	busy_clear_a: assert property (transfer_end_in &&
		!transfer_start_in |=> !transfer_busy_flag_out)
		else $error("busy not cleared on end");
	busy_hold_a: assert property (!transfer_start_in &&
		!transfer_end_in |=> $stable(transfer_busy_flag_out))
		else $error("busy moved without event");
endmodule : dtli_exec_properties

/* File: tb/dtli_seq_model.sv */
// Behavioural program sequencer feeding instruction words
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module dtli_seq_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Handshake with the executor
	input wire logic ready_in,
	input wire logic stall_in,
	output logic valid_out,
	output logic [31:0] instr_out
);
	// Words waiting to be fetched, filled by the bench
	logic [31:0] q [$];
	// A word stays on the lines until the executor takes it
	always @(posedge clk_in) begin
		if (rst_in) begin
			valid_out <= 1'b0;
			instr_out <= 32'hA5A5_A5A5;
		end else if (!valid_out || ready_in) begin
			if (q.size() != 0 && !stall_in) begin
				valid_out <= 1'b1;
				instr_out <= q.pop_front();
			end else begin
				valid_out <= 1'b0;
				// Idle lines must not look like a held word
				instr_out <= ~instr_out;
			end
		end
	end
endmodule : dtli_seq_model

/* File: tb/testbench.sv */
// Self-checking bench for the transfer and load-immediate executor
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module testbench;
	logic clk_sys_in, sys_rst_in, zero_flag_in, sign_flag_in, carry_flag_in;
	logic transfer_start_in, transfer_end_in, avs_read_in, avs_write_in;
	logic instr_valid_in, instr_ready_out, transfer_busy_flag_out;
	logic avs_waitrequest_out, seq_stall;
	logic [15:0] alu_high_part_in;
	logic [31:0] alu_low_part_in, avs_writedata_in, instr_in;
	logic [31:0] avs_readdata_out, rd_data, st, v, mem_val, sv;
	logic [5:0] avs_address_in;
	logic [dtli_pkg::PC_W-1:0] prog_counter_out;
	int failures, num_checks, cycles;
	// Registers reachable both as destinations and on the bus
	logic [3:0] dst_code [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB};
	logic [5:0] dst_addr [6] = '{dtli_pkg::REG_MUL_X,
		dtli_pkg::REG_PRODUCT_LOW, dtli_pkg::REG_READ_ADDR,
		dtli_pkg::REG_WRITE_ADDR, dtli_pkg::REG_LOOP, dtli_pkg::REG_RETURN};
	logic [5:0] cond_tab [8] = '{6'h21, 6'h01, 6'h22, 6'h02, 6'h24, 6'h04,
		6'h28, 6'h08};
	logic [31:0] exp_reg [6];
	logic [5:0] ptr [4];
	////////////////////////////////////////////////////////////////////////
	dtli_exec u_dut (.clk_sys_in, .sys_rst_in, .instr_valid_in, .instr_in,
		.instr_ready_out, .prog_counter_out, .zero_flag_in, .sign_flag_in,
		.carry_flag_in, .alu_high_part_in, .alu_low_part_in,
		.transfer_start_in, .transfer_end_in, .transfer_busy_flag_out,
		.avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
		.avs_readdata_out, .avs_waitrequest_out);
	dtli_seq_model u_seq (.clk_in(clk_sys_in), .rst_in(sys_rst_in),
		.ready_in(instr_ready_out), .stall_in(seq_stall),
		.valid_out(instr_valid_in), .instr_out(instr_in));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction : rnd
	function automatic logic [31:0] sx(input logic [31:0] x, input int msb);
		logic [31:0] m;
		m = 32'hFFFF_FFFF << msb;
		return x[msb] ? (x | m) : (x & ~m);
	endfunction : sx
	function automatic logic [31:0] f_simm(input logic [3:0] d,
		input logic [7:0] i);
		return {18'h0_0000, dtli_pkg::MOVE_SHORT_IMM, d, i};
	endfunction : f_simm
	function automatic logic [31:0] f_mov(input logic [3:0] d,
		input logic [3:0] s);
		return {18'h0_0000, dtli_pkg::MOVE_REG_RAM, d, 4'h0, s};
	endfunction : f_mov
	function automatic logic [31:0] f_ld(input logic [3:0] d,
		input logic [24:0] i);
		return {dtli_pkg::GRP_LOAD_IMM, d, 1'b0, i};
	endfunction : f_ld
	function automatic logic [31:0] f_ldc(input logic [3:0] d,
		input logic [5:0] c, input logic [18:0] i);
		return {dtli_pkg::GRP_LOAD_IMM, d, 1'b1, c, i};
	endfunction : f_ldc
	// Polarity bit set: any selected flag; clear: all selected flags low
	function automatic logic cond_ok(input logic [5:0] c, input logic t);
		logic any;
		any = |(c[3:0] & {t, carry_flag_in, sign_flag_in, zero_flag_in});
		return c[5] ? any : !any;
	endfunction : cond_ok
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge clk_sys_in);
		avs_read_in <= !wr;
		avs_write_in <= wr;
		avs_address_in <= a;
		avs_writedata_in <= d;
		do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
		rd_data = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : bus
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd_data, exp);
	endtask : rd_chk
	task automatic run();
		do @(posedge clk_sys_in);
		while (u_seq.q.size() != 0 || instr_valid_in !== 1'b0);
		@(posedge clk_sys_in);
	endtask : run
	task automatic chk_regs();
		for (int k = 0; k < 6; k++) rd_chk(dst_addr[k], exp_reg[k]);
		rd_chk(dtli_pkg::REG_POINTERS, {8'h00, ptr[3], ptr[2], ptr[1], ptr[0]});
	endtask : chk_regs
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// Random fetch stalls; a hang is cut short by the cycle ceiling
	always @(posedge clk_sys_in) begin
		cycles++;
		sv = rnd();
		seq_stall <= sv[0] & sv[1];
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		st = 32'h0000_003F;
		{sys_rst_in, zero_flag_in, sign_flag_in, carry_flag_in} = 4'h8;
		{transfer_start_in, transfer_end_in} = 2'h0;
		{avs_read_in, avs_write_in, avs_address_in} = 8'h00;
		{avs_writedata_in, alu_low_part_in, alu_high_part_in} = 80'h0;
		for (int k = 0; k < 6; k++) exp_reg[k] = 32'h0000_0000;
		for (int b = 0; b < 4; b++) ptr[b] = 6'h00;
		repeat (2) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		// Writes other than control are ignored, unmapped reads give zero
		bus(1'b1, dtli_pkg::REG_LOOP, 32'h1234_5678);
		chk_regs();
		rd_chk(dtli_pkg::REG_PROG_COUNTER, 32'h0000_0000);
		rd_chk(6'h28, 32'h0000_0000);
		bus(1'b1, dtli_pkg::REG_CONTROL, 32'h0000_0001);
		rd_chk(dtli_pkg::REG_CONTROL, 32'h0000_0001);
		// Back-to-back short immediates, sign bit at both edges
		for (int k = 0; k < 6; k++) begin
			v = rnd();
			if (k < 2) v[7:0] = (k == 1) ? 8'h7F : 8'h80;
			u_seq.q.push_back(f_simm(dst_code[k], v[7:0]));
			exp_reg[k] = sx({24'h00_0000, v[7:0]}, 7);
			// Return store is only as wide as the program counter
			if (k == 5) exp_reg[k] = {24'h00_0000, v[7:0]};
		end
		for (int b = 0; b < 4; b++) begin
			v = rnd();
			ptr[b] = v[5:0];
			u_seq.q.push_back(f_simm(4'(12 + b), {2'h0, v[5:0]}));
		end
		u_seq.q.push_back(f_simm(4'h8, 8'hFF));
		u_seq.q.push_back(f_simm(4'h9, 8'hFF));
		run();
		chk_regs();
		// Each bank: write with advance, read back plain then advancing
		for (int b = 0; b < 4; b++) begin
			v = rnd();
			mem_val = sx(v, b[0] ? 24 : 7);
			if (b[0]) u_seq.q.push_back(f_ld(4'(b), v[24:0]));
			else u_seq.q.push_back(f_simm(4'(b), v[7:0]));
			u_seq.q.push_back(f_simm(4'(12 + b), {2'h0, ptr[b]}));
			u_seq.q.push_back(f_mov(4'h4, 4'(b)));
			u_seq.q.push_back(f_mov(4'h5, 4'(4 + b)));
			ptr[b] = ptr[b] + dtli_pkg::PTR_STEP;
			exp_reg[0] = mem_val;
			exp_reg[1] = mem_val;
			run();
			chk_regs();
		end
		// Both ALU parts moved, high part sign-extended
		v = rnd();
		mem_val = rnd();
		@(posedge clk_sys_in);
		alu_low_part_in <= v;
		alu_high_part_in <= mem_val[15:0];
		u_seq.q.push_back(f_mov(4'h4, dtli_pkg::SRC_ALU_LOW));
		u_seq.q.push_back(f_mov(4'h5, dtli_pkg::SRC_ALU_HIGH));
		exp_reg[0] = v;
		exp_reg[1] = sx({16'h0000, mem_val[15:0]}, 15);
		run();
		chk_regs();
		// Unconditional loads; return store is no load destination
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 32'h0100_0000 : rnd();
			u_seq.q.push_back(f_ld(dst_code[k], v[24:0]));
			if (k < 5) exp_reg[k] = sx(v, 24);
		end
		run();
		chk_regs();
		// Every condition under random flags and busy state
		for (int n = 0; n < 32; n++) begin
			v = rnd();
			@(posedge clk_sys_in);
			{carry_flag_in, sign_flag_in, zero_flag_in} <= v[2:0];
			transfer_start_in <= v[3];
			transfer_end_in <= !v[3];
			@(posedge clk_sys_in);
			transfer_start_in <= 1'b0;
			transfer_end_in <= 1'b0;
			@(posedge clk_sys_in);
			chk(32'(transfer_busy_flag_out), 32'(v[3]));
			rd_chk(dtli_pkg::REG_STATUS, {30'h0000_0000, 1'b0, v[3]});
			mem_val = rnd();
			u_seq.q.push_back(f_ldc(4'h4, cond_tab[n % 8], mem_val[18:0]));
			if (cond_ok(cond_tab[n % 8], v[3])) exp_reg[0] = sx(mem_val, 18);
			run();
			rd_chk(dtli_pkg::REG_MUL_X, exp_reg[0]);
		end
		// Conditional call through the counter, then a plain jump
		@(posedge clk_sys_in);
		zero_flag_in <= 1'b1;
		bus(1'b0, dtli_pkg::REG_PROG_COUNTER, 32'h0000_0000);
		v = rnd();
		u_seq.q.push_back(f_ldc(4'hC, 6'h21, {11'h000, v[7:0]}));
		u_seq.q.push_back(f_simm(4'h4, v[15:8]));
		exp_reg[5] = {24'h00_0000, 8'(rd_data[7:0] + dtli_pkg::PC_STEP)};
		exp_reg[0] = sx({24'h00_0000, v[15:8]}, 7);
		run();
		chk_regs();
		rd_chk(dtli_pkg::REG_PROG_COUNTER, {24'h00_0000, v[7:0]});
		u_seq.q.push_back(f_ld(4'hC, {17'h0_0000, v[23:16]}));
		u_seq.q.push_back(f_simm(4'h8, 8'h00));
		run();
		rd_chk(dtli_pkg::REG_PROG_COUNTER, {24'h00_0000, v[23:16]});
		chk_regs();
		finish_test();
	end
endmodule : testbench

bind dtli_exec dtli_exec_properties u_props (.clk_sys_in, .sys_rst_in,
	.instr_valid_in, .instr_in, .instr_ready_out, .prog_counter_out,
	.zero_flag_in, .sign_flag_in, .carry_flag_in, .alu_high_part_in,
	.alu_low_part_in, .transfer_start_in, .transfer_end_in,
	.transfer_busy_flag_out, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out);
